// ### hw/ddrb_bank.v
// Drive data register bank with host and program access
`timescale 1ns/10ps
`default_nettype none
`include "ddrb_defines.vh"

module ddrb_bank (
    input wire sys_clk,
    input wire rst_b,
    input wire host_load_valid,
    input wire [7:0] host_load_addr,
    input wire [31:0] host_load_data,
    input wire host_read_valid,
    input wire [7:0] host_read_addr,
    input wire host_upload_valid,
    input wire [7:0] host_upload_addr,
    input wire [4:0] host_upload_count,
    input wire param_valid,
    input wire [1:0] param_sel,
    input wire [31:0] param_value,
    input wire prog_valid,
    input wire [2:0] prog_op,
    input wire [7:0] prog_dst,
    input wire [7:0] prog_src,
    input wire [6:0] prog_slot,
    input wire [31:0] prog_data,
    input wire [`DDRB_RO_BUS_W-1:0] ro_values,
    output reg prog_ready,
    output reg resp_valid,
    output reg [31:0] resp_data,
    output reg resp_last,
    output reg upload_busy,
    output reg [31:0] move_speed,
    output reg [31:0] speedup_rate,
    output reg [31:0] slowdown_rate,
    output reg [31:0] move_length
);

localparam ST_IDLE = 2'b01;
localparam ST_STREAM = 2'b10;

// Writable registers: A..Z, then user characters
reg [31:0] wr_mem [0:`DDRB_NWR-1];
reg [1:0] state;
reg [1:0] next_state;
reg [7:0] up_addr;
reg [7:0] next_up_addr;
reg [4:0] up_left;
reg [4:0] next_up_left;
reg rst_pend;
reg [7:0] rst_dst;
reg next_resp_valid;
reg [31:0] next_resp_data;
reg next_resp_last;
reg prog_we;
reg [5:0] prog_widx;
reg [31:0] prog_wdata;
reg par_we;
reg [5:0] par_widx;
reg [31:0] par_wdata;
reg host_we;
reg [5:0] host_widx;
reg nv_wr;
reg nv_rd;
reg [31:0] nv_wdata;
wire nv_rd_valid;
wire [31:0] nv_rd_data;
wire prog_take;
wire [31:0] src_val;
integer i;

////////////////////////////////////////////////////////////////////////
// Character decoding
function [1:0] kind_of;
    input [7:0] c;
    begin
        if (c >= `DDRB_CH_LC_A && c <= `DDRB_CH_LC_Z) begin
            kind_of = `DDRB_KIND_RO;
        end else if (c >= `DDRB_CH_UC_A && c <= `DDRB_CH_UC_Z) begin
            kind_of = `DDRB_KIND_RW;
        end else if (c >= `DDRB_CH_USR0_LO && c <= `DDRB_CH_USR0_HI) begin
            kind_of = `DDRB_KIND_USR;
        end else if (c >= `DDRB_CH_USR1_LO && c <= `DDRB_CH_USR1_HI) begin
            kind_of = `DDRB_KIND_USR;
        end else begin
            kind_of = `DDRB_KIND_NONE;
        end
    end
endfunction

function writable;
    input [7:0] c;
    begin
        writable = (kind_of(c) == `DDRB_KIND_RW) ||
                   (kind_of(c) == `DDRB_KIND_USR);
    end
endfunction

// 26 read/write plus 23 user plus 26 read-only makes 75
function [5:0] widx_of;
    input [7:0] c;
    reg [7:0] d;
    begin
        d = 8'h00;
        if (c >= `DDRB_CH_UC_A && c <= `DDRB_CH_UC_Z) begin
            d = c - `DDRB_CH_UC_A;
        end else if (c >= `DDRB_CH_USR0_LO && c <= `DDRB_CH_USR0_HI) begin
            d = c - `DDRB_CH_USR0_LO + {2'h0, `DDRB_USR0_BASE};
        end else if (c >= `DDRB_CH_USR1_LO && c <= `DDRB_CH_USR1_HI) begin
            d = c - `DDRB_CH_USR1_LO + {2'h0, `DDRB_USR1_BASE};
        end
        widx_of = d[5:0];
    end
endfunction

// Reads any register by character; unknown codes read zero
function [31:0] read_reg;
    input [7:0] c;
    reg [7:0] k;
    begin
        k = c - `DDRB_CH_LC_A;
        case (kind_of(c))
            `DDRB_KIND_RO: begin
                read_reg = ro_values[k[4:0] * 32 +: 32];
            end
            `DDRB_KIND_RW, `DDRB_KIND_USR: begin
                read_reg = wr_mem[widx_of(c)];
            end
            default: begin
                read_reg = `DDRB_RESET_VAL;
            end
        endcase
    end
endfunction

function [31:0] scale_speed;
    input [31:0] rps;
    begin
        scale_speed = rps * `DDRB_SPEED_SCALE;
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Queued program operations
assign prog_take = prog_valid && prog_ready;
assign src_val = read_reg(prog_src);

always @* begin
    prog_we = 1'b0;
    prog_widx = widx_of(prog_dst);
    prog_wdata = prog_data;
    nv_wr = 1'b0;
    nv_rd = 1'b0;
    nv_wdata = src_val;
    if (prog_take) begin
        case (prog_op)
            `DDRB_OP_LOAD: begin
                prog_we = writable(prog_dst);
            end
            `DDRB_OP_STORE: begin
                nv_wr = 1'b1;
            end
            `DDRB_OP_RESTORE: begin
                nv_rd = 1'b1;
            end
            `DDRB_OP_COPY: begin
                prog_we = writable(prog_dst);
                prog_wdata = src_val;
            end
            `DDRB_OP_INC: begin
                prog_we = writable(prog_dst);
                prog_wdata = read_reg(prog_dst) + 32'h00000001;
            end
            `DDRB_OP_DEC: begin
                prog_we = writable(prog_dst);
                prog_wdata = read_reg(prog_dst) - 32'h00000001;
            end
            default: begin
                prog_we = 1'b0;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Dedicated parameter commands and host loads
always @* begin
    par_we = param_valid;
    par_wdata = param_value;
    case (param_sel)
        `DDRB_PSEL_SPEED: begin
            par_widx = `DDRB_IDX_SPEED;
            par_wdata = scale_speed(param_value);
        end
        `DDRB_PSEL_SPEEDUP: begin
            par_widx = `DDRB_IDX_SPEEDUP;
        end
        `DDRB_PSEL_SLOWDOWN: begin
            par_widx = `DDRB_IDX_SLOWDOWN;
        end
        `DDRB_PSEL_LENGTH: begin
            par_widx = `DDRB_IDX_LENGTH;
        end
        default: begin
            par_widx = `DDRB_IDX_SPEED;
            par_we = 1'b0;
        end
    endcase
end

always @* begin
    // Loads into read-only or unknown codes are dropped
    host_we = host_load_valid && writable(host_load_addr);
    host_widx = widx_of(host_load_addr);
end

////////////////////////////////////////////////////////////////////////
// Register array; later writes in this block win
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        for (i = 0; i < `DDRB_NWR; i = i + 1) begin
            wr_mem[i] <= `DDRB_RESET_VAL;
        end
    end else begin
        if (rst_pend && nv_rd_valid && writable(rst_dst)) begin
            wr_mem[widx_of(rst_dst)] <= nv_rd_data;
        end
        if (prog_we) begin
            wr_mem[prog_widx] <= prog_wdata;
        end
        if (par_we) begin
            wr_mem[par_widx] <= par_wdata;
        end
        if (host_we) begin
            wr_mem[host_widx] <= host_load_data;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Restore bookkeeping and program back-pressure
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        rst_pend <= 1'b0;
        rst_dst <= 8'h00;
        prog_ready <= 1'b1;
    end else begin
        rst_pend <= nv_rd;
        rst_dst <= prog_dst;
        // One stall cycle keeps program order across a restore
        prog_ready <= !nv_rd;
    end
end

ddrb_nv_store u_nv (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wr_en(nv_wr),
    .wr_slot(prog_slot),
    .wr_data(nv_wdata),
    .rd_en(nv_rd),
    .rd_slot(prog_slot),
    .rd_valid(nv_rd_valid),
    .rd_data(nv_rd_data)
);

////////////////////////////////////////////////////////////////////////
// Host read and block upload
always @* begin
    next_state = state;
    next_up_addr = up_addr;
    next_up_left = up_left;
    next_resp_valid = 1'b0;
    next_resp_data = `DDRB_RESET_VAL;
    next_resp_last = 1'b0;
    case (state)
        ST_IDLE: begin
            if (host_read_valid) begin
                next_resp_valid = 1'b1;
                next_resp_data = read_reg(host_read_addr);
                next_resp_last = 1'b1;
            end else if (host_upload_valid) begin
                next_state = ST_STREAM;
                next_up_addr = host_upload_addr;
                if (host_upload_count == 5'h00) begin
                    next_up_left = 5'h01;
                end else if (host_upload_count > `DDRB_UPLOAD_MAX) begin
                    next_up_left = `DDRB_UPLOAD_MAX;
                end else begin
                    next_up_left = host_upload_count;
                end
            end
        end
        ST_STREAM: begin
            next_resp_valid = 1'b1;
            next_resp_data = read_reg(up_addr);
            next_resp_last = (up_left == 5'h01);
            next_up_addr = up_addr + 8'h01;
            next_up_left = up_left - 5'h01;
            if (up_left == 5'h01) begin
                next_state = ST_IDLE;
            end
        end
        default: begin
            next_state = ST_IDLE;
        end
    endcase
end

always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        state <= ST_IDLE;
        up_addr <= 8'h00;
        up_left <= 5'h00;
        resp_valid <= 1'b0;
        resp_data <= `DDRB_RESET_VAL;
        resp_last <= 1'b0;
        upload_busy <= 1'b0;
    end else begin
        state <= next_state;
        up_addr <= next_up_addr;
        up_left <= next_up_left;
        resp_valid <= next_resp_valid;
        resp_data <= next_resp_data;
        resp_last <= next_resp_last;
        upload_busy <= (next_state == ST_STREAM);
    end
end

////////////////////////////////////////////////////////////////////////
// Motion parameters presented to the profile logic
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        move_speed <= `DDRB_RESET_VAL;
        speedup_rate <= `DDRB_RESET_VAL;
        slowdown_rate <= `DDRB_RESET_VAL;
        move_length <= `DDRB_RESET_VAL;
    end else begin
        move_speed <= wr_mem[`DDRB_IDX_SPEED];
        speedup_rate <= wr_mem[`DDRB_IDX_SPEEDUP];
        slowdown_rate <= wr_mem[`DDRB_IDX_SLOWDOWN];
        move_length <= wr_mem[`DDRB_IDX_LENGTH];
    end
end

endmodule // ddrb_bank
`default_nettype wire

// ### shared/ddrb_defines.vh
// Constants for the drive data register bank
`ifndef DDRB_DEFINES_VH
`define DDRB_DEFINES_VH

// Data path and bank sizes
`define DDRB_DW 32
`define DDRB_NREG 75
`define DDRB_NRO 26
`define DDRB_NWR 49
`define DDRB_RO_BUS_W 832
`define DDRB_RESET_VAL 32'h00000000

// Storage slots, numbered 1 to 100
`define DDRB_SLOT_FIRST 7'h01
`define DDRB_SLOT_LAST 7'h64
`define DDRB_NSLOT 100

// Character codes of the register categories
`define DDRB_CH_LC_A 8'h61
`define DDRB_CH_LC_Z 8'h7A
`define DDRB_CH_UC_A 8'h41
`define DDRB_CH_UC_Z 8'h5A
`define DDRB_CH_USR0_LO 8'h30
`define DDRB_CH_USR0_HI 8'h40
`define DDRB_CH_USR1_LO 8'h5B
`define DDRB_CH_USR1_HI 8'h60
`define DDRB_USR0_BASE 6'h1A
`define DDRB_USR1_BASE 6'h2B

// Register kinds
`define DDRB_KIND_NONE 2'h0
`define DDRB_KIND_RO 2'h1
`define DDRB_KIND_RW 2'h2
`define DDRB_KIND_USR 2'h3

// Writable-array indexes of the motion parameters (V, A, B, D)
`define DDRB_IDX_SPEED 6'h15
`define DDRB_IDX_SPEEDUP 6'h00
`define DDRB_IDX_SLOWDOWN 6'h01
`define DDRB_IDX_LENGTH 6'h03

// Raw velocity counts per rev/s: 2400 raw equals 10 rev/s
`define DDRB_SPEED_RAW 2400
`define DDRB_SPEED_RPS 10
`define DDRB_SPEED_SCALE 32'h000000F0

// Dedicated parameter command selects
`define DDRB_PSEL_SPEED 2'h0
`define DDRB_PSEL_SPEEDUP 2'h1
`define DDRB_PSEL_SLOWDOWN 2'h2
`define DDRB_PSEL_LENGTH 2'h3

// Queued program operations
`define DDRB_OP_LOAD 3'h0
`define DDRB_OP_STORE 3'h1
`define DDRB_OP_RESTORE 3'h2
`define DDRB_OP_COPY 3'h3
`define DDRB_OP_INC 3'h4
`define DDRB_OP_DEC 3'h5

// Block upload length limit
`define DDRB_UPLOAD_MAX 5'h10

`endif

// ### hw/ddrb_nv_store.v
// Non-volatile storage slot array of the data register bank
`timescale 1ns/10ps
`default_nettype none
`include "ddrb_defines.vh"

module ddrb_nv_store (
    input wire sys_clk,
    input wire rst_b,
    input wire wr_en,
    input wire [6:0] wr_slot,
    input wire [31:0] wr_data,
    input wire rd_en,
    input wire [6:0] rd_slot,
    output reg rd_valid,
    output reg [31:0] rd_data
);

// Slot n lives at entry n-1; contents are never reset
reg [31:0] slot_mem [0:`DDRB_NSLOT-1];

////////////////////////////////////////////////////////////////////////
function slot_ok;
    input [6:0] s;
    begin
        slot_ok = (s >= `DDRB_SLOT_FIRST) && (s <= `DDRB_SLOT_LAST);
    end
endfunction

////////////////////////////////////////////////////////////////////////
always @(posedge sys_clk) begin
    if (wr_en && slot_ok(wr_slot)) begin
        slot_mem[wr_slot - 7'h01] <= wr_data;
    end
end

always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        rd_valid <= 1'b0;
        rd_data <= `DDRB_RESET_VAL;
    end else begin
        rd_valid <= rd_en && slot_ok(rd_slot);
        if (rd_en && slot_ok(rd_slot)) begin
            rd_data <= slot_mem[rd_slot - 7'h01];
        end
    end
end

endmodule // ddrb_nv_store
`default_nettype wire

// ### sim/ddrb_bank_sva.sv
// Port assertions for the drive data register bank
`timescale 1ns/10ps
`default_nettype none
module ddrb_bank_sva (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic host_load_valid,
    input wire logic [7:0] host_load_addr,
    input wire logic [31:0] host_load_data,
    input wire logic host_read_valid,
    input wire logic host_upload_valid,
    input wire logic [4:0] host_upload_count,
    input wire logic param_valid,
    input wire logic [1:0] param_sel,
    input wire logic [31:0] param_value,
    input wire logic prog_valid,
    input wire logic [2:0] prog_op,
    input wire logic prog_ready,
    input wire logic resp_valid,
    input wire logic resp_last,
    input wire logic upload_busy,
    input wire logic [31:0] move_speed,
    input wire logic [31:0] move_length
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire logic start = host_upload_valid && !host_read_valid && !upload_busy;
    wire logic quiet = !host_load_valid && !param_valid && !prog_valid;
    wire logic took = prog_valid && prog_ready;
    ////////////////////////////////////////////////////////////////////////
    a_read_beat: assert property (
        host_read_valid && !upload_busy |=> resp_valid && resp_last)
        else $error("read answer missing");
    a_upload_gap: assert property (
        start |=> upload_busy && !resp_valid ##1 resp_valid)
        else $error("upload start timing wrong");
    a_upload_full: assert property (
        start && host_upload_count == 5'h10 |=> ##1
        (resp_valid && !resp_last)[*8] ##1 (resp_valid && !resp_last)[*7]
        ##1 resp_valid && resp_last)
        else $error("upload of sixteen wrong");
    a_speed_scale: assert property (
        param_valid && param_sel == 2'h0 && !host_load_valid && !prog_valid
        |=> ##1 move_speed == $past(param_value, 2) * 32'h000000F0)
        else $error("speed scaling wrong");
    a_load_length: assert property (
        host_load_valid && host_load_addr == 8'h44
        |=> ##1 move_length == $past(host_load_data, 2))
        else $error("host length load lost");
    a_length_hold: assert property (
        quiet && prog_ready |=> ##1 $stable(move_length))
        else $error("length changed without a write");
    a_restore_stall: assert property (
        took && prog_op == 3'h2 |=> !prog_ready ##1 prog_ready)
        else $error("restore stall wrong");
    a_prog_flow: assert property (
        took && prog_op != 3'h2 |=> prog_ready)
        else $error("program port stalled");
    c_upload_full: cover property (start && host_upload_count == 5'h10);
    c_restore: cover property (took && prog_op == 3'h2);
    c_collide: cover property (host_load_valid && took);
endmodule // ddrb_bank_sva
`default_nettype wire

// ### sim/ddrb_host_model.sv
// Behavioural host on the command link of the register bank
`timescale 1ns/10ps
`default_nettype none
module ddrb_host_model (
    input wire logic sys_clk,
    input wire logic resp_valid,
    input wire logic [31:0] resp_data,
    input wire logic resp_last,
    output logic host_load_valid,
    output logic [7:0] host_load_addr,
    output logic [31:0] host_load_data,
    output logic host_read_valid,
    output logic [7:0] host_read_addr,
    output logic host_upload_valid,
    output logic [7:0] host_upload_addr,
    output logic [4:0] host_upload_count,
    output logic param_valid,
    output logic [1:0] param_sel,
    output logic [31:0] param_value
);
    logic [31:0] got [0:15];
    int got_n;
    initial begin
        {host_load_valid, host_read_valid, host_upload_valid} = 3'h0;
        {host_load_addr, host_read_addr, host_upload_addr} = 24'h000000;
        {host_load_data, param_value} = 64'h0000000000000000;
        {param_valid, param_sel, host_upload_count} = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // Released data lines show the inverse of the last value
    task automatic load(input logic [7:0] ch, input logic [31:0] val);
        @(negedge sys_clk);
        host_load_valid = 1'b1;
        host_load_addr = ch;
        host_load_data = val;
        @(negedge sys_clk);
        host_load_valid = 1'b0;
        host_load_data = ~val;
    endtask
    task automatic param(input logic [1:0] sel, input logic [31:0] val);
        @(negedge sys_clk);
        param_valid = 1'b1;
        param_sel = sel;
        param_value = val;
        @(negedge sys_clk);
        param_valid = 1'b0;
        param_value = ~val;
    endtask
    // Gather answer beats up to the last one
    task automatic collect();
        got_n = 0;
        for (int i = 0; i < 24; i++) begin
            if (resp_valid === 1'b1) begin
                if (got_n < 16) begin
                    got[got_n] = resp_data;
                end
                got_n++;
            end
            if (resp_valid === 1'b1 && resp_last === 1'b1) begin
                break;
            end
            @(negedge sys_clk);
        end
    endtask
    task automatic read(input logic [7:0] ch);
        @(negedge sys_clk);
        host_read_valid = 1'b1;
        host_read_addr = ch;
        @(negedge sys_clk);
        host_read_valid = 1'b0;
        host_read_addr = ~ch;
        collect();
    endtask
    task automatic upload(input logic [7:0] ch, input logic [4:0] n);
        @(negedge sys_clk);
        host_upload_valid = 1'b1;
        host_upload_addr = ch;
        host_upload_count = n;
        @(negedge sys_clk);
        host_upload_valid = 1'b0;
        host_upload_addr = ~ch;
        collect();
    endtask
endmodule // ddrb_host_model
`default_nettype wire

// ### sim/test_drive_data_register_bank.sv
// Self-checking bench for the drive data register bank
`timescale 1ns/10ps
`default_nettype none
module test_drive_data_register_bank;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic prog_valid = 1'b0;
    logic [2:0] prog_op = 3'h0;
    logic [7:0] prog_dst = 8'h00;
    logic [7:0] prog_src = 8'h00;
    logic [6:0] prog_slot = 7'h00;
    logic [31:0] prog_data = 32'h00000000;
    logic [831:0] ro_values;
    logic host_load_valid, host_read_valid, host_upload_valid, param_valid;
    logic [7:0] host_load_addr, host_read_addr, host_upload_addr;
    logic [31:0] host_load_data, param_value, resp_data;
    logic [4:0] host_upload_count;
    logic [1:0] param_sel;
    logic prog_ready, resp_valid, resp_last, upload_busy;
    logic [31:0] move_speed, speedup_rate, slowdown_rate, move_length;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    always #2.5 sys_clk = ~sys_clk;
    ddrb_bank i_dut (.*);
    ddrb_host_model i_host (.*);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ro(input int k);
        return 32'hA5000000 + k;
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic expect_reg(input logic [7:0] ch, input logic [31:0] exp);
        i_host.read(ch);
        check("read beats", i_host.got_n, 1);
        check("read value", i_host.got[0], exp);
    endtask
    task automatic prog(input logic [2:0] op, input logic [7:0] dst,
        input logic [7:0] src, input logic [6:0] slot, input logic [31:0] v);
        @(negedge sys_clk);
        for (int i = 0; i < 4 && prog_ready !== 1'b1; i++) begin
            @(negedge sys_clk);
        end
        prog_valid = 1'b1;
        {prog_op, prog_dst, prog_src, prog_slot, prog_data} =
            {op, dst, src, slot, v};
        @(negedge sys_clk);
        prog_valid = 1'b0;
        prog_data = ~v;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_all_chars();
        logic [7:0] c;
        logic [31:0] exp_v;
        for (int i = 0; i < 75; i++) begin
            c = 8'h30 + i[7:0];
            i_host.load(c, {24'h5A5A00, c});
        end
        for (int i = 0; i < 75; i++) begin
            c = 8'h30 + i[7:0];
            exp_v = c > 8'h60 ? ro(i - 49) : {24'h5A5A00, c};
            expect_reg(c, exp_v);
        end
        expect_reg(8'h7B, 32'h00000000);
        expect_reg(8'h2F, 32'h00000000);
        $display("test all_chars done");
    endtask
    task automatic t_param();
        logic [7:0] chs [4] = '{8'h56, 8'h41, 8'h42, 8'h44};
        logic [31:0] exp_v;
        for (int s = 0; s < 4; s++) begin
            i_host.param(s[1:0], 32'h0000000A + s);
            exp_v = s == 0 ? 32'h00000960 : 32'h0000000A + s;
            expect_reg(chs[s], exp_v);
        end
        repeat (20) @(negedge sys_clk);
        check("move_speed", move_speed, 32'h00000960);
        check("speedup_rate", speedup_rate, 32'h0000000B);
        check("slowdown_rate", slowdown_rate, 32'h0000000C);
        check("move_length", move_length, 32'h0000000D);
        $display("test param done");
    endtask
    task automatic t_upload();
        for (int i = 0; i < 16; i++) begin
            i_host.load(8'h41 + i[7:0], 32'h00C0FFEE + i);
        end
        i_host.upload(8'h41, 5'h10);
        check("upload beats", i_host.got_n, 16);
        for (int i = 0; i < 16; i++) begin
            check("upload", i_host.got[i], 32'h00C0FFEE + i);
        end
        i_host.upload(8'h61, 5'h01);
        check("single beats", i_host.got_n, 1);
        check("single value", i_host.got[0], ro(0));
        i_host.upload(8'h41, 5'h14);
        check("clamp beats", i_host.got_n, 16);
        check("clamp last", i_host.got[15], 32'h00C0FFFD);
        i_host.upload(8'h62, 5'h00);
        check("zero beats", i_host.got_n, 1);
        check("zero value", i_host.got[0], ro(1));
        $display("test upload done");
    endtask
    task automatic t_prog();
        prog(3'h0, 8'h37, 8'h00, 7'h00, 32'h11223344);
        prog(3'h1, 8'h00, 8'h37, 7'h64, 32'h00000000);
        prog(3'h1, 8'h00, 8'h38, 7'h01, 32'h00000000);
        prog(3'h0, 8'h37, 8'h00, 7'h00, 32'h00000000);
        prog(3'h2, 8'h37, 8'h00, 7'h64, 32'h00000000);
        prog(3'h2, 8'h39, 8'h00, 7'h01, 32'h00000000);
        prog(3'h0, 8'h38, 8'h00, 7'h00, 32'h13572468);
        prog(3'h2, 8'h38, 8'h00, 7'h00, 32'h00000000);
        expect_reg(8'h37, 32'h11223344);
        expect_reg(8'h39, 32'h5A5A0038);
        expect_reg(8'h38, 32'h13572468);
        prog(3'h3, 8'h62, 8'h61, 7'h00, 32'h00000000);
        prog(3'h3, 8'h51, 8'h61, 7'h00, 32'h00000000);
        expect_reg(8'h62, ro(1));
        expect_reg(8'h51, ro(0));
        expect_reg(8'h61, ro(0));
        prog(3'h0, 8'h39, 8'h00, 7'h00, 32'hFFFFFFFF);
        prog(3'h4, 8'h39, 8'h00, 7'h00, 32'h00000000);
        expect_reg(8'h39, 32'h00000000);
        prog(3'h5, 8'h39, 8'h00, 7'h00, 32'h00000000);
        expect_reg(8'h39, 32'hFFFFFFFF);
        $display("test prog done");
    endtask
    task automatic t_collide();
        fork
            i_host.load(8'h44, 32'hAAAA0001);
            prog(3'h0, 8'h44, 8'h00, 7'h00, 32'hBBBB0002);
        join
        expect_reg(8'h44, 32'hAAAA0001);
        $display("test collide done");
    endtask
    // Mid-run reset clears volatile state, keeps the storage slots
    task automatic t_reset();
        @(negedge sys_clk);
        rst_b = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("reset ready", prog_ready, 32'h00000001);
        check("reset busy", upload_busy, 32'h00000000);
        check("reset length", move_length, 32'h00000000);
        rst_b = 1'b1;
        expect_reg(8'h39, 32'h00000000);
        prog(3'h2, 8'h37, 8'h00, 7'h64, 32'h00000000);
        expect_reg(8'h37, 32'h11223344);
        $display("test reset done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end
    initial begin
        for (int k = 0; k < 26; k++) begin
            ro_values[32*k +: 32] = ro(k);
        end
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        t_all_chars();
        t_param();
        t_upload();
        t_prog();
        t_collide();
        t_reset();
        results();
    end
endmodule // test_drive_data_register_bank
bind ddrb_bank ddrb_bank_sva i_sva (.*);
`default_nettype wire
